// >>> design/usb_cfg_pkg.sv
package usb_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_WINDOW_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SUBSYSTEM = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CAP_PTR = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_RELEASE = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_LOAD_CTRL = 8'h70;

  // Field layout
  localparam int BASE_LSB = 8;
  localparam int IRQ_PIN_LSB = 8;
  localparam int SUBSYS_LSB = 16;

  // Reset values
  localparam logic [23:0] WINDOW_BASE_RST = 24'h000000;
  localparam logic [7:0] CAP_PTR_RST = 8'h80;
  localparam logic [7:0] IRQ_LINE_RST = 8'h00;
  localparam logic [7:0] RELEASE_RST = 8'h20;
  localparam logic [7:0] IRQ_PIN_F0 = 8'h01;
  localparam logic [7:0] IRQ_PIN_F1 = 8'h02;
  localparam logic [7:0] IRQ_PIN_F2 = 8'h03;
  localparam logic [1:0] EHCI_FUNC = 2'd2;

  // Side-band load targets
  typedef enum logic [1:0] {
    LD_VENDOR = 2'b00,
    LD_SUBSYS = 2'b01,
    LD_CAPPTR = 2'b11
  } load_sel_t;

  typedef struct packed {
    logic valid;
    load_sel_t sel;
    logic [15:0] data;
  } load_req_t;

endpackage

// >>> design/usb_host_config_header_regs.sv
// Function
// (R1) Window base bits 31:8 writable, 7:0 zero; the code stores it only in the EHCI function, others read zero
// (R2) Read-only subsystem vendor and device identifiers
// (R3) Read-only capability pointer, default 80h
// (R4) Interrupt routing byte read-write, resets 00h
// (R5) Legacy interrupt select 01h/02h/03h by function
// (R6) EHCI only: release number 20h read-only
// (R7) Host writes never change read-only fields
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module usb_host_config_header_regs
  import usb_cfg_pkg::*;
#(
  parameter logic [1:0] FUNC_NUM = 2'd2,
  // Arbitrary neutral identity values
  parameter logic [15:0] SUBSYS_VENDOR_RST = 16'h1234,
  parameter logic [15:0] SUBSYS_OHCI_RST = 16'h0001,
  parameter logic [15:0] SUBSYS_EHCI_RST = 16'h0002
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire load_req_t load_req,
  output logic [DATA_W-1:0] window_base
);

  // Elaboration-time refusal of a function number with no interrupt select code
  if (FUNC_NUM > 2'd2) begin : g_func_chk
    $error("FUNC_NUM must be 0, 1 or 2");
  end

  localparam bit IS_EHCI = (FUNC_NUM == EHCI_FUNC);
  localparam logic [7:0] IRQ_PIN_VAL =
    (FUNC_NUM == 2'd0) ? IRQ_PIN_F0 : (FUNC_NUM == 2'd1) ? IRQ_PIN_F1 : IRQ_PIN_F2;
  localparam logic [15:0] SUBSYS_RST = IS_EHCI ? SUBSYS_EHCI_RST : SUBSYS_OHCI_RST;

  logic [23:0] base_r;
  logic [15:0] vendor_r;
  logic [15:0] subsys_r;
  logic [7:0] cap_ptr_r;
  logic [7:0] irq_line_r;
  logic [DATA_W-1:0] rd_nxt;
  logic mapped;
  logic wr_acc;
  logic rd_acc;

  // Zero-wait slave: every access phase completes in one cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_nxt = '0;
    unique case (paddr)
      OFS_WINDOW_BASE: rd_nxt = IS_EHCI ? {base_r, 8'h00} : '0; // [R1]
      OFS_SUBSYSTEM: rd_nxt = {subsys_r, vendor_r}; // [R2]
      OFS_CAP_PTR: rd_nxt = {24'h000000, cap_ptr_r}; // [R3]
      OFS_INTERRUPT: rd_nxt = {16'h0000, IRQ_PIN_VAL, irq_line_r}; // [R5]
      OFS_RELEASE: rd_nxt = IS_EHCI ? {24'h000000, RELEASE_RST} : '0; // [R6]
      default: mapped = 1'b0;
    endcase
  end

  // Window base; low byte is never stored so it reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= WINDOW_BASE_RST;
    end else if (IS_EHCI && wr_acc && paddr == OFS_WINDOW_BASE) begin
      for (int b = 1; b < 4; b++) begin
        if (pstrb[b]) begin
          base_r[(b-1)*8 +: 8] <= pwdata[b*8 +: 8]; // [R1]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_line_r <= IRQ_LINE_RST;
    end else if (wr_acc && paddr == OFS_INTERRUPT && pstrb[0]) begin
      irq_line_r <= pwdata[7:0]; // [R4]
    end
  end

  // Read-only defaults: only the side-band load path touches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vendor_r <= SUBSYS_VENDOR_RST;
      subsys_r <= SUBSYS_RST;
      cap_ptr_r <= CAP_PTR_RST;
    end else if (load_req.valid) begin
      unique case (load_req.sel)
        LD_VENDOR: vendor_r <= load_req.data; // [R2] [R7]
        LD_SUBSYS: subsys_r <= load_req.data; // [R2] [R7]
        LD_CAPPTR: cap_ptr_r <= load_req.data[7:0]; // [R3] [R7]
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_acc) begin
        prdata <= rd_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_base <= '0;
    end else begin
      window_base <= IS_EHCI ? {base_r, 8'h00} : '0; // [R1]
    end
  end

  cap_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && !load_req.valid) |=> $stable(cap_ptr_r) && $stable(vendor_r)
      && $stable(subsys_r)) else $error("Host write changed read-only field"); // [R7]

  base_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    window_base[7:0] == 8'h00) else $error("Window base low byte not zero"); // [R1]

  base_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (IS_EHCI && wr_acc && paddr == OFS_WINDOW_BASE && pstrb == 4'hf)
      |=> ##1 window_base[31:8] == $past(pwdata[31:8], 2))
    else $error("Window base write lost"); // [R1]

  line_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == OFS_INTERRUPT && pstrb[0]) |=> irq_line_r == $past(pwdata[7:0]))
    else $error("Interrupt routing write lost"); // [R4]

  pin_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == OFS_INTERRUPT) |=> prdata[15:8] == IRQ_PIN_VAL && pready)
    else $error("Interrupt select read wrong"); // [R5]

  rel_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == OFS_RELEASE) |=> prdata == (IS_EHCI ? 32'h00000020 : 32'h0))
    else $error("Release number read wrong"); // [R6]

  cap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (load_req.valid && load_req.sel == LD_CAPPTR) |=> cap_ptr_r == $past(load_req.data[7:0]))
    else $error("Capability pointer load lost"); // [R3]

  subsys_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == OFS_SUBSYSTEM) |=> prdata == $past({subsys_r, vendor_r}))
    else $error("Subsystem identifier read wrong"); // [R2]

  // Stored fields move only on their own write or load strobe
  base_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    !(wr_acc && paddr == OFS_WINDOW_BASE) |=> $stable(base_r))
    else $error("Window base changed without write");

  base_rd_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (rd_acc && paddr == OFS_WINDOW_BASE) |=> prdata[7:0] == 8'h00)
    else $error("Window base low byte read nonzero");

  base_copy_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    1'b1 |=> window_base == (IS_EHCI ? {$past(base_r), 8'h00} : 32'h00000000))
    else $error("Window base copy wrong");

  vendor_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (load_req.valid && load_req.sel == LD_VENDOR) |=> vendor_r == $past(load_req.data))
    else $error("Vendor identifier load lost");

  subsys_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (load_req.valid && load_req.sel == LD_SUBSYS) |=> subsys_r == $past(load_req.data))
    else $error("Subsystem identifier load lost");

  cap_rd_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (rd_acc && paddr == OFS_CAP_PTR) |=> prdata == {24'h000000, $past(cap_ptr_r)})
    else $error("Capability pointer read wrong");

  line_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    !(wr_acc && paddr == OFS_INTERRUPT && pstrb[0]) |=> $stable(irq_line_r))
    else $error("Interrupt routing changed without write");

  line_rd_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (rd_acc && paddr == OFS_INTERRUPT) |=> prdata[7:0] == $past(irq_line_r))
    else $error("Interrupt routing read wrong");

  pin_hi_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (rd_acc && paddr == OFS_INTERRUPT) |=> prdata[31:16] == 16'h0000)
    else $error("Interrupt word upper half nonzero");

  // A load-free cycle leaves every read-only default alone
  ro_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    !load_req.valid |=> $stable(cap_ptr_r) && $stable(vendor_r) && $stable(subsys_r))
    else $error("Read-only field changed without load");

  err_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    (psel && !penable && !mapped) |=> pslverr && pready)
    else $error("Unmapped access not flagged");

  ok_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    (psel && !penable && mapped) |=> !pslverr && pready)
    else $error("Mapped access flagged as error");

  rdy_one_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    pready |=> !pready)
    else $error("Ready held beyond one cycle");

  // Release number is a constant, so only the read path can break it
  rel_hi_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    (rd_acc && paddr == OFS_RELEASE) |=> prdata[31:8] == 24'h000000)
    else $error("Release word upper bits nonzero");

endmodule // usb_host_config_header_regs

`default_nettype wire

// >>> sim/cfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
  import usb_cfg_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [DATA_W-1:0] rdat;
  logic rerr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
  end
  // Routing byte is written by the host in the access phase, not during setup
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= {4{w}};
    @(posedge pclk);
    penable <= 1'b1;
    // No timeout of its own: pready ends the wait, else the bench watchdog ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data inverted so a stale value cannot pass
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // cfg_host_model
`default_nettype wire

// >>> sim/usb_host_config_header_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_config_header_regs_test import usb_cfg_pkg::*; ;
  localparam logic [15:0] VND = 16'h1234;
  localparam logic [15:0] SSYS = 16'h0002;
  localparam logic [15:0] SSYS_OHCI = 16'h0001;
  logic [DATA_W-1:0] prdata0, window_base0;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, window_base;
  logic [3:0] pstrb;
  load_req_t load_req;
  int num_errors, cmp_count;
  usb_host_config_header_regs #(.SUBSYS_VENDOR_RST(VND), .SUBSYS_EHCI_RST(SSYS)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .load_req, .window_base);
  // Function 0 copy on the same bus: only its read data and window base are watched
  usb_host_config_header_regs #(.FUNC_NUM(2'd0)) uut_f0 (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata(prdata0), .pready(), .pslverr(), .load_req, .window_base(window_base0));
  cfg_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr);
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host.xfer(1'b0, a, '0);
    check(host.rdat, exp);
  endtask
  task automatic load(input load_sel_t s, input logic [15:0] d);
    load_req <= '{valid: 1'b1, sel: s, data: d};
    @(posedge pclk);
    load_req <= '{valid: 1'b0, sel: s, data: ~d};
    @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #20us;
    num_errors++;
    print_verdict();
  end
  initial begin
    presetn = 1'b0;
    load_req = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_WINDOW_BASE, 32'h0);
    rd(OFS_SUBSYSTEM, {SSYS, VND});
    check(prdata0, {SSYS_OHCI, VND});
    rd(OFS_CAP_PTR, 32'h80);
    rd(OFS_INTERRUPT, 32'h300);
    check(prdata0, 32'h100);
    rd(OFS_RELEASE, 32'h20);
    check(prdata0, 32'h0);
    $display("Test reset values done");
    host.xfer(1'b1, OFS_WINDOW_BASE, 32'h12345678);
    rd(OFS_WINDOW_BASE, 32'h12345600);
    check(prdata0, 32'h0);
    check(window_base, 32'h12345600);
    check(window_base0, 32'h0);
    host.xfer(1'b1, OFS_INTERRUPT, 32'hffffffa5);
    rd(OFS_INTERRUPT, 32'h3a5);
    host.xfer(1'b1, OFS_SUBSYSTEM, '1);
    host.xfer(1'b1, OFS_CAP_PTR, '1);
    host.xfer(1'b1, OFS_RELEASE, '1);
    rd(OFS_SUBSYSTEM, {SSYS, VND});
    rd(OFS_CAP_PTR, 32'h80);
    rd(OFS_RELEASE, 32'h20);
    $display("Test host writes done");
    host.xfer(1'b1, OFS_LOAD_CTRL, '1);
    check({31'h0, host.rerr}, 32'h1);
    rd(OFS_LOAD_CTRL, 32'h0);
    check({31'h0, host.rerr}, 32'h1);
    $display("Test unmapped done");
    load(LD_VENDOR, 16'habcd);
    load(LD_SUBSYS, 16'h5a5a);
    load(LD_CAPPTR, 16'h0040);
    rd(OFS_SUBSYSTEM, 32'h5a5aabcd);
    rd(OFS_CAP_PTR, 32'h40);
    $display("Test load path done");
    print_verdict();
  end
endmodule // usb_host_config_header_regs_test
`default_nettype wire
